//--- verilog/eid_pkg.sv
// eid_pkg: register map, field layout and operation codes of the
// extended instruction decoder.
// assumes a 32-bit AXI4-Lite register bus and 20-bit operands.
package eid_pkg;
    localparam int          AXI_AW       = 8;
    localparam logic [7:0]  ADDR_PREFIX  = 8'h00;
    localparam logic [7:0]  ADDR_OPCTL   = 8'h04;
    localparam logic [7:0]  ADDR_SRC     = 8'h08;
    localparam logic [7:0]  ADDR_DST     = 8'h0C;
    localparam logic [7:0]  ADDR_FLAGS   = 8'h10;
    localparam logic [7:0]  ADDR_RESULT  = 8'h14;
    localparam logic [7:0]  ADDR_DECODE  = 8'h18;
    localparam logic [7:0]  ADDR_SP      = 8'h1C;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // prefix word layout
    localparam logic [4:0]  PREFIX_OPC   = 5'h03;
    localparam int          PFX_OPC_LSB  = 11;
    localparam int          PFX_SRC_LSB  = 7;
    localparam int          PFX_AL_BIT   = 6;
    localparam int          PFX_REP_BIT  = 7;
    localparam int          PFX_DST_LSB  = 0;
    // operation control layout
    localparam int          OPC_OP_LSB   = 0;
    localparam int          OPC_BW_BIT   = 5;
    localparam int          OPC_N_LSB    = 6;
    localparam int          OPC_RM_BIT   = 10;
    // status flag positions
    localparam int          FLAG_C       = 0;
    localparam int          FLAG_Z       = 1;
    localparam int          FLAG_N       = 2;
    localparam int          FLAG_V       = 3;
    // reset values and operand size masks
    localparam logic [15:0] PREFIX_RST   = 16'h0000;
    localparam logic [19:0] SP_RST       = 20'h0_0000;
    localparam logic [19:0] MASK_BYTE    = 20'h0_00FF;
    localparam logic [19:0] MASK_WORD    = 20'h0_FFFF;
    localparam logic [19:0] MASK_ADDR    = 20'hF_FFFF;

    typedef enum logic [4:0] {
        OP_MOV, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_DADD,
        OP_BIT, OP_BIC, OP_BIS, OP_XOR, OP_AND,
        OP_CALL, OP_MULTI_REGISTER_POP, OP_MULTI_REGISTER_PUSH, OP_PUSH,
        OP_MULTI_ROTATE_CARRY_RIGHT, OP_MULTI_UNSIGNED_RIGHT, OP_MULTI_ARITH_RIGHT, OP_MULTI_ARITH_LEFT,
        OP_RRC, OP_RRU, OP_RRA, OP_SWPB, OP_SXT
    } eid_op_t;

    // encoded as {length bit, byte/word bit}
    typedef enum logic [1:0] {
        SZ_RSV, SZ_ADDR, SZ_WORD, SZ_BYTE
    } eid_size_t;
endpackage

//--- verilog/eid_prefix_dec.sv
// eid_prefix_dec: combinational split of a candidate prefix word.
// assumes the caller supplies the low nibble of the named register.
`timescale 1ns/10ps
module eid_prefix_dec
    import eid_pkg::*;
(
    input  wire logic [15:0] word,
    input  wire logic        reg_mode,
    input  wire logic [3:0]  reg_low,
    output logic             is_prefix,
    output logic             len_bit,
    output logic [3:0]       src_hi,
    output logic [3:0]       dst_hi,
    output logic [4:0]       rep_count
);
    logic [3:0] rep_m1;

    // bits 5:4 are never looked at
    assign is_prefix = word[15:PFX_OPC_LSB] == PREFIX_OPC;
    assign len_bit   = word[PFX_AL_BIT];
    assign src_hi    = word[PFX_SRC_LSB +: 4];
    assign dst_hi    = word[PFX_DST_LSB +: 4];
    // count held as n-1, from the word or from the register
    assign rep_m1    = (reg_mode && word[PFX_REP_BIT]) ? reg_low
                                                       : word[3:0];
    assign rep_count = {1'b0, rep_m1} + 5'h01;
endmodule

//--- verilog/eid_bcd_add.sv
// eid_bcd_add: combinational nibble-ripple decimal adder with carry per digit.
// assumes both operands hold valid decimal digits.
`timescale 1ns/10ps
module eid_bcd_add #(
    parameter int NIB = 5
) (
    input  wire logic [4*NIB-1:0] a,
    input  wire logic [4*NIB-1:0] b,
    input  wire logic             cin,
    output logic [4*NIB-1:0]      sum,
    output logic [NIB-1:0]        cout
);
    logic [NIB:0] chain;

    assign chain[0] = cin;
    genvar g;
    generate
        for (g = 0; g < NIB; g++)
        begin : g_dig
            logic [4:0] raw;
            logic       over;
            assign raw  = {1'b0, a[4*g +: 4]} + {1'b0, b[4*g +: 4]}
                        + {4'h0, chain[g]};
            assign over = raw > 5'h09;
            assign sum[4*g +: 4] = over ? 4'(raw + 5'h06) : raw[3:0];
            assign cout[g]       = over;
            assign chain[g+1]    = over;
        end
    endgenerate
endmodule

//--- verilog/eid_core.sv
// eid_core: extension prefix decoder and extended operation unit
// behind an AXI4-Lite slave; software loads prefix, operands and an
// operation code, and the block returns result, flags and decode.
// assumes a single clock and a master that keeps AXI4-Lite rules.
`timescale 1ns/10ps
module eid_core
    import eid_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp
);
    logic              aw_full_q, w_full_q, bvalid_q, rvalid_q, go_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0]       w_data_q, rdata_q, wr_val;
    logic [3:0]        w_strb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic              commit, rd_take;
    logic [15:0]       prefix_q, opctl_q, src_q;
    logic [19:0]       dst_q, result_q, sp_q;
    logic [3:0]        flags_q;
    logic              wrote_q;
    logic              is_prefix, len_bit, eff_len, eff_bw;
    logic [3:0]        src_hi, dst_hi;
    logic [4:0]        rep_count;
    eid_op_t           op;
    eid_size_t         sz;
    logic              op_bad, size_err;
    logic [19:0]       m, a, d, r, top, b_op;
    logic [20:0]       t;
    logic [3:0]        f;
    logic              we, upd, cy;
    logic [4:0]        cnt;
    logic [6:0]        delta;
    logic [19:0]       sp_d;
    logic [19:0]       bcd_sum;
    logic [4:0]        bcd_c;

    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] nw,
                                          logic [3:0]  st);
        logic [31:0] o;
        o = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                o[8*i +: 8] = nw[8*i +: 8];
        return o;
    endfunction

    // ---------------- AXI4-Lite slave ----------------
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    // address and data may arrive in either order; commit needs both
    assign commit  = aw_full_q && w_full_q && !bvalid_q;
    assign rd_take = s_axi_arvalid && !rvalid_q;

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid && !aw_full_q)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (commit)
            aw_full_q <= 1'b0;

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (s_axi_wvalid && !w_full_q)
        begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (commit)
            w_full_q <= 1'b0;

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (commit)
        begin
            bvalid_q <= 1'b1;
            case (aw_addr_q)
                ADDR_PREFIX, ADDR_OPCTL, ADDR_SRC, ADDR_DST,
                ADDR_FLAGS, ADDR_SP:
                    bresp_q <= RESP_OKAY;
                default:
                    bresp_q <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_PREFIX: rdata_q <= {16'h0000, prefix_q};
                ADDR_OPCTL:  rdata_q <= {16'h0000, opctl_q};
                ADDR_SRC:    rdata_q <= {12'h000, src_hi, src_q};
                ADDR_DST:    rdata_q <= {12'h000, dst_q};
                ADDR_FLAGS:  rdata_q <= {28'h000_0000, flags_q};
                ADDR_RESULT: rdata_q <= {12'h000, result_q};
                ADDR_DECODE: rdata_q <= {5'h00, delta, wrote_q,
                                         (sz == SZ_ADDR) ? 2'h2 : 2'h1,
                                         rep_count, dst_hi, src_hi,
                                         size_err, sz, is_prefix};
                ADDR_SP:     rdata_q <= {12'h000, sp_q};
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;

    // ---------------- software registers ----------------
    assign wr_val = merge(32'h0000_0000, w_data_q, w_strb_q);

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            prefix_q <= PREFIX_RST;
            opctl_q  <= '0;
            src_q    <= '0;
            dst_q    <= '0;
        end
        else if (commit)
            case (aw_addr_q)
                ADDR_PREFIX:
                    prefix_q <= 16'(merge({16'h0, prefix_q}, w_data_q,
                                          w_strb_q));
                ADDR_OPCTL:
                    opctl_q <= 16'(merge({16'h0, opctl_q}, w_data_q,
                                         w_strb_q));
                ADDR_SRC:
                    src_q <= 16'(merge({16'h0, src_q}, w_data_q,
                                       w_strb_q));
                ADDR_DST:
                    dst_q <= 20'(merge({12'h0, dst_q}, w_data_q,
                                       w_strb_q));
                default:
                    prefix_q <= prefix_q;
            endcase

    // a write to the operation register starts one execution
    always_ff @(posedge aclk)
        if (!aresetn)
            go_q <= 1'b0;
        else
            go_q <= commit && aw_addr_q == ADDR_OPCTL && |w_strb_q;

    // ---------------- decode ----------------
    eid_prefix_dec u_pfx (
        .word      (prefix_q),
        .reg_mode  (opctl_q[OPC_RM_BIT]),
        .reg_low   (dst_q[3:0]),
        .is_prefix (is_prefix),
        .len_bit   (len_bit),
        .src_hi    (src_hi),
        .dst_hi    (dst_hi),
        .rep_count (rep_count)
    );

    assign op_bad = opctl_q[OPC_OP_LSB +: 5] > 5'(OP_SXT);
    assign op     = eid_op_t'(opctl_q[OPC_OP_LSB +: 5]);
    // a non-prefix word leaves plain 16/8-bit operation
    assign eff_len = is_prefix ? len_bit : 1'b1;
    // multi, swap and sign extend take size from the length bit alone,
    // so length 0 means the 20-bit form rather than the reserved code
    assign eff_bw  = (op inside {OP_SWPB, OP_SXT, OP_MULTI_ROTATE_CARRY_RIGHT, OP_MULTI_UNSIGNED_RIGHT, OP_MULTI_ARITH_RIGHT,
                                 OP_MULTI_ARITH_LEFT, OP_MULTI_REGISTER_PUSH, OP_MULTI_REGISTER_POP})
                   ? !eff_len : opctl_q[OPC_BW_BIT];
    assign sz = eid_size_t'({eff_len, eff_bw});
    // byte form of swap and sign extend is not applicable
    assign size_err = sz == SZ_RSV || op_bad
                   || ((op == OP_SWPB || op == OP_SXT)
                       && opctl_q[OPC_BW_BIT]);

    always_comb
        case (sz)
            SZ_BYTE: m = MASK_BYTE;
            SZ_WORD: m = MASK_WORD;
            default: m = MASK_ADDR;
        endcase
    assign top = m ^ (m >> 1);
    // the source operand carries the prefix's upper nibble; the destination uses dst_q
    assign a = {src_hi, src_q} & m;
    assign d = dst_q & m;

    eid_bcd_add #(.NIB(5)) u_bcd (
        .a    (a),
        .b    (d),
        .cin  (flags_q[FLAG_C]),
        .sum  (bcd_sum),
        .cout (bcd_c)
    );

    // push/pop counts run 1..16, shift counts 1..4
    assign cnt = (op == OP_MULTI_REGISTER_PUSH || op == OP_MULTI_REGISTER_POP)
               ? {1'b0, opctl_q[OPC_N_LSB +: 4]} + 5'h01
               : {3'b000, opctl_q[OPC_N_LSB +: 2]} + 5'h01;
    assign delta = (sz == SZ_ADDR) ? {cnt, 2'b00}
                                   : {1'b0, cnt, 1'b0};

    // ---------------- operation unit ----------------
    always_comb
    begin
        logic [19:0] v;
        logic        c, nc;
        v    = d;
        c    = flags_q[FLAG_C];
        nc   = 1'b0;
        cy   = 1'b0;
        t    = '0;
        b_op = '0;
        r    = d;
        f    = flags_q;
        we   = 1'b1;
        upd  = 1'b1;
        sp_d = sp_q;
        case (op)
            OP_MOV, OP_BIC, OP_BIS:
            begin
                upd = 1'b0;
                r = op == OP_MOV ? a : op == OP_BIC ? (~a & d) : (a | d);
            end
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP:
            begin
                b_op = (op == OP_ADD || op == OP_ADDC) ? a : (~a & m);
                cy = op == OP_ADD ? 1'b0 : (op == OP_SUB || op == OP_CMP)
                   ? 1'b1 : c;
                t = {1'b0, d} + {1'b0, b_op} + {20'h0_0000, cy};
                r = t[19:0] & m;
                we = op != OP_CMP;
                f[FLAG_C] = |({t[20], t[19:0] & ~m} & {1'b1, top << 1});
                f[FLAG_V] = ((d & top) == (b_op & top))
                         && ((r & top) != (d & top));
            end
            OP_DADD:
            begin
                r = bcd_sum & m;
                f[FLAG_C] = sz == SZ_BYTE ? bcd_c[1] : sz == SZ_WORD
                          ? bcd_c[3] : bcd_c[4];
                f[FLAG_V] = 1'b0;
            end
            OP_BIT, OP_AND, OP_XOR:
            begin
                r  = op == OP_XOR ? (a ^ d) : (a & d);
                we = op != OP_BIT;
                f[FLAG_V] = op == OP_XOR && |(a & d & top);
            end
            OP_CALL:
            begin
                r    = a;
                upd  = 1'b0;
                sp_d = sp_q - 20'h0_0004;
            end
            OP_PUSH:
            begin
                r    = a;
                upd  = 1'b0;
                sp_d = sp_q - ((sz == SZ_ADDR) ? 20'h0_0004 : 20'h0_0002);
            end
            OP_MULTI_REGISTER_PUSH, OP_MULTI_REGISTER_POP:
            begin
                upd  = 1'b0;
                sp_d = op == OP_MULTI_REGISTER_PUSH ? sp_q - {13'h0000, delta}
                                      : sp_q + {13'h0000, delta};
                r    = sp_d;
            end
            OP_MULTI_ROTATE_CARRY_RIGHT, OP_MULTI_UNSIGNED_RIGHT, OP_MULTI_ARITH_RIGHT, OP_MULTI_ARITH_LEFT, OP_RRC, OP_RRU, OP_RRA:
            begin
                f[FLAG_V] = 1'b0;
                for (int i = 0; i < 4; i++)
                    if (i < cnt || (i == 0))
                        if (op inside {OP_RRC, OP_RRU, OP_RRA} && i > 0)
                            v = v;
                        else if (op == OP_MULTI_ARITH_LEFT)
                        begin
                            nc = |(v & top);
                            v  = (v << 1) & m;
                            f[FLAG_V] = f[FLAG_V]
                                     || (nc != |(v & top));
                            c  = nc;
                        end
                        else
                        begin
                            nc = v[0];
                            v  = v >> 1;
                            if ((op inside {OP_MULTI_ROTATE_CARRY_RIGHT, OP_RRC} && c)
                                || (op inside {OP_MULTI_ARITH_RIGHT, OP_RRA}
                                    && |(d & top)))
                                v = v | top;
                            c  = nc;
                        end
                r = v;
                f[FLAG_C] = c;
            end
            OP_SWPB:
            begin
                r   = {d[19:16], d[7:0], d[15:8]} & m;
                upd = 1'b0;
            end
            OP_SXT:
            begin
                r = d[7] ? (d | (m & ~MASK_BYTE)) : (d & MASK_BYTE);
                f[FLAG_V] = 1'b0;
            end
            default:
            begin
                we  = 1'b0;
                upd = 1'b0;
            end
        endcase
        f[FLAG_N] = |(r & top);
        f[FLAG_Z] = (r & m) == 20'h0_0000;
        if (op inside {OP_BIT, OP_AND, OP_XOR, OP_SXT})
            f[FLAG_C] = !f[FLAG_Z];
        if (!upd)
            f = flags_q;
    end

    // an invalid size or code leaves all state untouched
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            result_q <= '0;
            wrote_q  <= 1'b0;
        end
        else if (go_q && !size_err)
        begin
            result_q <= r;
            wrote_q  <= we;
        end

    // execution wins over a software write in the same cycle
    always_ff @(posedge aclk)
        if (!aresetn)
            flags_q <= '0;
        else if (go_q && !size_err)
            flags_q <= f;
        else if (commit && aw_addr_q == ADDR_FLAGS)
            flags_q <= wr_val[3:0];

    always_ff @(posedge aclk)
        if (!aresetn)
            sp_q <= SP_RST;
        else if (go_q && !size_err)
            sp_q <= sp_d;
        else if (commit && aw_addr_q == ADDR_SP)
            sp_q <= 20'(merge({12'h0, sp_q}, w_data_q, w_strb_q));
endmodule

//--- tb/eid_core_sva.sv
// eid_core_sva: bus handshake and decode read-back checks.
// assumes it is bound to eid_core and sees its ports only.
`timescale 1ns/10ps
module eid_core_sva
    import eid_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] ar_q;
    // last read address, so read data can be tied to its register
    always_ff @(posedge aclk)
        if (s_axi_arvalid && s_axi_arready)
            ar_q <= s_axi_araddr;
    wire dec_rd = s_axi_rvalid && ar_q == ADDR_DECODE;
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_ar_ans;
        s_ar_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_w_ans;
        s_w_take |=> ##1 s_axi_bvalid;
    endproperty
    property p_unmap;
        s_ar_take ##0 s_axi_araddr > ADDR_SP
            |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    property p_dec_sz;
        dec_rd && s_axi_rdata[2:1] == SZ_RSV |-> s_axi_rdata[3];
    endproperty
    property p_dec_wd;
        dec_rd && s_axi_rdata[19] |-> s_axi_rdata[18:17] ==
            (s_axi_rdata[2:1] == SZ_ADDR ? 2'h2 : 2'h1);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer moved");
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");
    a_b_done: assert property (p_b_done) else $error("bvalid stuck");
    a_r_done: assert property (p_r_done) else $error("rvalid stuck");
    a_ar_ans: assert property (p_ar_ans) else $error("no read answer");
    a_w_ans: assert property (p_w_ans) else $error("no write answer");
    a_unmap: assert property (p_unmap) else $error("unmapped read ok");
    a_dec_sz: assert property (p_dec_sz)
        else $error("size not flagged");
    a_dec_wd: assert property (p_dec_wd)
        else $error("word count");
endmodule
bind eid_core eid_core_sva u_sva (.*);

//--- tb/eid_prog_mem.sv
// eid_prog_mem: program memory model holding extension prefix words.
// assumes a combinational read; the bench sets the address.
`timescale 1ns/10ps
module eid_prog_mem
(
    input  wire logic [2:0]  addr,
    output logic      [15:0] word
);
    always_comb
        case (addr)
            3'h0:    word = 16'h1D45;
            3'h1:    word = 16'h1D75; // reserved bits set on purpose
            3'h2:    word = 16'h1800;
            3'h3:    word = 16'h1840;
            default: word = 16'h0000;
        endcase
endmodule

//--- tb/tb_top.sv
// tb_top: register-level bench for the extended decoder.
// assumes prefix words come from the program memory model.
`timescale 1ns/10ps
module tb_top
    import eid_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] pm_word;
    logic [2:0]  pm_addr;
    int          bad_count, compares;

    eid_core DUT (.*);
    eid_prog_mem u_mem (.addr(pm_addr), .word(pm_word));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ready is looked at mid-cycle, where it has settled for the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, dn;
        dn = 0;
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        while (!dn)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            dn = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, dn;
        dn = 0;
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        while (!dn)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            dn = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
    endtask
    task automatic op(input logic [2:0] i, input logic [31:0] c);
        pm_addr = i;
        @(negedge aclk);
        wr(ADDR_PREFIX, {16'h0000, pm_word});
        wr(ADDR_OPCTL, c);
    endtask
    task automatic t_reset;
        rd(ADDR_DECODE);
        chk(v, 32'h0022_1004);
        rd(8'h20);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h24, 32'h0000_0001);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    task automatic t_alu;
        wr(ADDR_SRC, 32'h0000_0001);
        wr(ADDR_DST, 32'h0000_FFFF);
        wr(ADDR_FLAGS, 32'h0000_0000);
        op(1, 32'h0000_0001);
        rd(ADDR_DECODE);
        chk(v & 32'h000E_0FFF, 32'h000A_05A5);
        rd(ADDR_RESULT);
        chk(v, 32'h0000_0000);
        rd(ADDR_FLAGS);
        chk(v, 32'h0000_0003);
        wr(ADDR_SRC, 32'h0000_FF0F);
        wr(ADDR_DST, 32'h0000_0FFC);
        op(3, 32'h0000_002B);
        rd(ADDR_RESULT);
        chk(v, 32'h0000_000C);
        rd(ADDR_FLAGS);
        chk(v, 32'h0000_0001);
        wr(ADDR_FLAGS, 32'h0000_000F);
        op(3, 32'h0000_0000);
        rd(ADDR_RESULT);
        chk(v, 32'h0000_FF0F);
        rd(ADDR_FLAGS);
        chk(v, 32'h0000_000F);
        op(2, 32'h0000_0001);
        rd(ADDR_DECODE);
        chk(v & 32'h0000_000F, 32'h0000_0009);
    endtask
    task automatic t_ext;
        wr(ADDR_DST, 32'h0000_0080);
        op(2, 32'h0000_0018);
        rd(ADDR_RESULT);
        chk(v, 32'h000F_FF80);
        rd(ADDR_FLAGS);
        chk(v & 32'h0000_000E, 32'h0000_0004);
        op(2, 32'h0000_0038);
        rd(ADDR_DECODE);
        chk(v & 32'h0006_0008, 32'h0004_0008);
        wr(ADDR_DST, 32'h0000_00F8);
        op(3, 32'h0000_00D1);
        rd(ADDR_RESULT);
        chk(v, 32'h0000_000F);
        rd(ADDR_FLAGS);
        chk(v, 32'h0000_0001);
    endtask
    task automatic t_rot;
        wr(ADDR_FLAGS, 32'h0000_0001);
        wr(ADDR_DST, 32'h0000_0003);
        op(0, 32'h0000_0050);
        rd(ADDR_RESULT);
        chk(v, 32'h0000_C000);
        rd(ADDR_FLAGS);
        chk(v, 32'h0000_0005);
        rd(ADDR_DECODE);
        chk(v & 32'h0001_F000, 32'h0000_6000);
    endtask
    task automatic t_stack;
        wr(ADDR_SP, 32'h0000_0000);
        op(2, 32'h0000_03CE);
        rd(ADDR_SP);
        chk(v, 32'h000F_FFC0);
        rd(ADDR_DECODE);
        chk((v >> 20) & 32'h0000_007F, 32'h0000_0040);
        op(3, 32'h0000_03CD);
        rd(ADDR_SP);
        chk(v, 32'h000F_FFE0);
    endtask

    initial
    begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    initial
    begin
        #200us;
        bad_count++;
        stop_test;
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
         s_axi_wstrb, pm_addr} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_alu;
        t_ext;
        t_rot;
        t_stack;
        stop_test;
    end
endmodule
